// ---- srg_button.sv ----
// Model of the manual reset source.
// Assumes go and len change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module srg_button (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [5:0] len,
  output logic            man_n
);
  logic [5:0] cnt_ff = 6'h00;
  // Once released the line reads high through the pull-up.
  assign man_n = (cnt_ff == 6'h00);
  always @(negedge clk) begin
    if (go) begin
      cnt_ff <= len;
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
    end
  end
endmodule
`default_nettype wire

// ---- srg_map.vh ----
// Constants for the supervisory reset generator: timing figures and derived cycle counts.
// Assumes a 40 MHz system clock; times are kept in their own unit next to the derived counts.
`ifndef SRG_MAP_VH
`define SRG_MAP_VH

`define SRG_CLK_PERIOD_PS     25000
// Glitch rejection window on the manual input, in ns.
`define SRG_GLITCH_NS         200
// Delay from the manual input falling to the reset output asserting, in ns.
`define SRG_MAN_DELAY_NS      250
// Least manual pulse that must always give a reset, in ns.
`define SRG_MIN_PULSE_NS      1000
// Least reset timeout, in ms.
`define SRG_TIMEOUT_MS        10
// Level of the internal reset flag while the block itself is in reset.
`define SRG_RESET_ASSERTED    1'b1
// Cycle counts derived from the times above; the timeout is kept within 32 bits.
`define SRG_GLITCH_CYC        ((`SRG_GLITCH_NS * 1000) / `SRG_CLK_PERIOD_PS)
`define SRG_MAN_DELAY_CYC     ((`SRG_MAN_DELAY_NS * 1000) / `SRG_CLK_PERIOD_PS)
`define SRG_TIMEOUT_CYC       ((`SRG_TIMEOUT_MS * 1000000) / (`SRG_CLK_PERIOD_PS / 1000))

`endif

// ---- srg_reset_gen.v ----
// Supervisory reset generator: supply-low and manual reset causes, glitch filter, timeout.
// Assumes all inputs are synchronous to sys_clk; the supply-low flag comes from an analog comparator.
//
// Function
// - The active-low reset output falls as soon as supply-low appears, or once the manual input has stayed low through the filter delay.
// - The active-high reset output rises under the same causes.
// - Reset stays asserted while any cause is present and then for the full timeout after both clear, as long as clk_en is high.
// - With clk_en high, a held-low manual input asserts reset about 250 ns after its falling edge.
// - Manual low pulses shorter than about 200 ns are ignored; pulses of 1 us or more always reset while clk_en is high.
// - An open manual input reads high through the pull-up and so is inactive.
`timescale 1ns/1ps
`default_nettype none
`include "srg_map.vh"

module srg_reset_gen #(
  parameter integer TIMEOUT_CYC = `SRG_TIMEOUT_CYC,
  parameter integer MAN_DLY_CYC = `SRG_MAN_DELAY_CYC,
  parameter integer CNT_W       = 24
) (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire clk_en,
  input  wire supply_low_in,
  input  wire manual_reset_n_in,
  output wire reset_n_out,
  output wire reset_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State codes of the sequencer.
  localparam [1:0] ST_ASSERT  = 2'h0;
  localparam [1:0] ST_TIMEOUT = 2'h1;
  localparam [1:0] ST_RUN     = 2'h2;

  // Limits are held at the width of their counters, so that no compare pads or drops bits.
  // MAN_DLY_CYC must lie between the glitch window in cycles and 256.
  localparam [31:0]      TMO_LAST_W = TIMEOUT_CYC - 1;
  localparam [31:0]      MAN_LAST_W = MAN_DLY_CYC - 1;
  localparam [CNT_W-1:0] TMO_LAST   = TMO_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] TMO_ZERO   = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] TMO_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [7:0]       MAN_LAST   = MAN_LAST_W[7:0];
  localparam [7:0]       MAN_ZERO   = 8'h00;
  localparam [7:0]       MAN_ONE    = 8'h01;

  // True in every state that keeps the outputs asserted.
  function holds_reset;
    input [1:0] st;
    begin
      holds_reset = (st != ST_RUN);
    end
  endfunction

  // A cause is present while supply is low or the filtered manual input is active.
  function cause_of;
    input supply_low;
    input man_active;
    begin
      cause_of = supply_low | man_active;
    end
  endfunction

  // True once the timeout counter has counted its last cycle.
  function tmo_expired;
    input [CNT_W-1:0] cnt;
    begin
      tmo_expired = (cnt >= TMO_LAST);
    end
  endfunction

  // True once the manual input has been low for the full filter length.
  function man_expired;
    input [7:0] cnt;
    begin
      man_expired = (cnt >= MAN_LAST);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and their next values.
  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [CNT_W-1:0] tmo_cnt_ff;
  reg  [CNT_W-1:0] nxt_tmo_cnt;
  reg  [7:0]       man_cnt_ff;
  reg  [7:0]       nxt_man_cnt;
  reg              man_act_ff;
  reg              nxt_man_act;
  reg              rst_ff;
  reg              nxt_rst;
  wire             man_low;
  wire             cause;
  wire             assert_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Manual input filter. Low must persist MAN_DLY_CYC sampled cycles, which is longer
  // than the glitch window, so shorter pulses never reach the outputs.
  assign man_low = (manual_reset_n_in == 1'b0);

  always @* begin
    nxt_man_cnt = man_cnt_ff;
    nxt_man_act = man_act_ff;
    if (!man_low) begin
      nxt_man_cnt = MAN_ZERO;
      nxt_man_act = 1'b0;
    end else if (man_expired(man_cnt_ff)) begin
      nxt_man_act = 1'b1;
    end else begin
      nxt_man_cnt = man_cnt_ff + MAN_ONE;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      man_cnt_ff <= MAN_ZERO;
    end else if (clk_en) begin
      man_cnt_ff <= nxt_man_cnt;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      man_act_ff <= 1'b0;
    end else if (clk_en) begin
      man_act_ff <= nxt_man_act;
    end
  end

  // Either cause alone keeps the sequencer in its assert state.
  assign cause = cause_of(supply_low_in, man_act_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: assert while a cause stands, then count the full timeout with no cause.
  // A cause seen during the count sends it back, so the count always starts from zero.
  always @* begin
    nxt_state   = state_ff;
    nxt_tmo_cnt = tmo_cnt_ff;
    case (state_ff)
      // Held here while any cause is present.
      ST_ASSERT: begin
        nxt_tmo_cnt = TMO_ZERO;
        if (!cause) begin
          nxt_state = ST_TIMEOUT;
        end
      end

      // Counting the timeout; reset is still asserted.
      ST_TIMEOUT: begin
        if (cause) begin
          nxt_state   = ST_ASSERT;
          nxt_tmo_cnt = TMO_ZERO;
        end else if (tmo_expired(tmo_cnt_ff)) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_tmo_cnt = tmo_cnt_ff + TMO_ONE;
        end
      end

      // Reset released; any cause asserts it again.
      ST_RUN: begin
        nxt_tmo_cnt = TMO_ZERO;
        if (cause) begin
          nxt_state = ST_ASSERT;
        end
      end

      default: begin
        nxt_state   = ST_ASSERT;
        nxt_tmo_cnt = TMO_ZERO;
      end
    endcase
  end

  always @* begin
    nxt_rst = holds_reset(nxt_state);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers; all of them hold still while clk_en is low.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_ASSERT;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_cnt_ff <= TMO_ZERO;
    end else if (clk_en) begin
      tmo_cnt_ff <= nxt_tmo_cnt;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_ff <= `SRG_RESET_ASSERTED;
    end else if (clk_en) begin
      rst_ff <= nxt_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs. The cause also asserts them combinationally, so that the assert path adds
  // no clock of latency; the release comes from the registered flag, except with clk_en low and the flag clear, when it follows the cause alone.
  assign assert_any  = rst_ff | cause;
  assign reset_out   = assert_any;
  assign reset_n_out = ~assert_any;

endmodule
`default_nettype wire

// ---- srg_reset_gen_assertions.sv ----
// Checker for the reset generator ports.
// Assumes one clock domain and rst_b as the only reset.
`timescale 1ns/1ps
`default_nettype none
module srg_reset_gen_assertions #(
  parameter integer TIMEOUT_CYC = 20,
  parameter integer MAN_DLY_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic reset_n_out,
  input wire logic reset_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Consecutive enabled cycles with the manual input low, saturating.
  logic [7:0]  man_low_run_ff;
  // Enabled cycles since the last cause that the filtered inputs present.
  logic [31:0] quiet_run_ff;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      man_low_run_ff <= 8'h00;
      quiet_run_ff   <= 32'h0000_0000;
    end else if (clk_en) begin
      if (manual_reset_n_in) begin
        man_low_run_ff <= 8'h00;
      end else if (man_low_run_ff != 8'hFF) begin
        man_low_run_ff <= man_low_run_ff + 8'h01;
      end
      if (supply_low_in || (man_low_run_ff >= MAN_DLY_CYC)) begin
        quiet_run_ff <= 32'h0000_0000;
      end else if (quiet_run_ff != 32'hFFFF_FFFF) begin
        quiet_run_ff <= quiet_run_ff + 32'h0000_0001;
      end
    end
  end
  out_inverse_a: assert property (reset_out == !reset_n_out)
    else $error("outputs not inverse");
  supply_cause_a: assert property (supply_low_in |-> reset_out && !reset_n_out)
    else $error("supply low without reset");
  manual_cause_a: assert property ((man_low_run_ff >= MAN_DLY_CYC) |-> reset_out)
    else $error("held manual low without reset");
  glitch_reject_a: assert property ($rose(reset_out) && !supply_low_in
    |-> $past(manual_reset_n_in, 8) == 1'b0)
    else $error("short manual pulse gave reset");
  timeout_hold_a: assert property ((quiet_run_ff <= TIMEOUT_CYC) |-> reset_out)
    else $error("reset released inside timeout");
  full_timeout_a: assert property ($fell(reset_out) |-> quiet_run_ff > TIMEOUT_CYC)
    else $error("reset ended before full timeout");
endmodule
bind srg_reset_gen srg_reset_gen_assertions #(
  .TIMEOUT_CYC(TIMEOUT_CYC),
  .MAN_DLY_CYC(MAN_DLY_CYC)
) u_chk (
  .sys_clk          (sys_clk),
  .rst_b            (rst_b),
  .clk_en           (clk_en),
  .supply_low_in    (supply_low_in),
  .manual_reset_n_in(manual_reset_n_in),
  .reset_n_out      (reset_n_out),
  .reset_out        (reset_out)
);
`default_nettype wire

// ---- srg_reset_gen_bench.sv ----
// Bench for the reset generator with a short timeout.
// Assumes srg_button drives the manual input.
`timescale 1ns/1ps
`default_nettype none
module srg_reset_gen_bench;
  logic       clk        = 1'b0;
  logic       rst_b      = 1'b0;
  logic       clk_en     = 1'b1;
  logic       sup        = 1'b0;
  logic       go         = 1'b0;
  logic [5:0] len        = 6'h00;
  wire logic  man_n;
  wire logic  rn;
  wire logic  r;
  int         failures   = 0;
  int         num_checks = 0;

  initial begin
    forever begin
      #12.5 clk = ~clk;
    end
  end

  srg_reset_gen #(
    .TIMEOUT_CYC(20)
  ) u_dut (
    .sys_clk          (clk),
    .rst_b            (rst_b),
    .clk_en           (clk_en),
    .supply_low_in    (sup),
    .manual_reset_n_in(man_n),
    .reset_n_out      (rn),
    .reset_out        (r)
  );

  srg_button u_btn (
    .clk  (clk),
    .go   (go),
    .len  (len),
    .man_n(man_n)
  );

  task automatic chk(input logic seen, input logic expected);
    num_checks++;
    if (seen !== expected) begin
      failures++;
      $display("BAD %0t reset output %b, wanted %b", $time, seen, expected);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // The model takes go at the next falling edge and then holds the line low for w cycles.
  task automatic press(input logic [5:0] w);
    len <= w;
    go  <= 1'b1;
    cyc(1);
    go  <= 1'b0;
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t_start;
    cyc(5);
    rst_b = 1'b1;
    cyc(1);
    chk(r, 1'b1);
    chk(rn, 1'b0);
    cyc(19);
    chk(r, 1'b1);
    cyc(6);
    chk(r, 1'b0);
    chk(rn, 1'b1);
  endtask

  task automatic t_glitch;
    press(6'h07);
    cyc(5);
    chk(r, 1'b0);
    cyc(7);
    chk(r, 1'b0);
  endtask

  task automatic t_manual;
    press(6'h28);
    cyc(8);
    chk(r, 1'b0);
    cyc(4);
    chk(r, 1'b1);
    chk(rn, 1'b0);
    cyc(43);
    chk(r, 1'b1);
    cyc(10);
    chk(r, 1'b0);
  endtask

  task automatic t_supply;
    sup = 1'b1;
    #1;
    chk(r, 1'b1);
    chk(rn, 1'b0);
    cyc(1);
    sup = 1'b0;
    cyc(10);
    sup = 1'b1;
    cyc(1);
    sup = 1'b0;
    cyc(18);
    chk(r, 1'b1);
    cyc(5);
    chk(r, 1'b0);
  endtask

  // A low clock enable must hold the timeout where it stands.
  task automatic t_freeze;
    sup = 1'b1;
    cyc(1);
    sup = 1'b0;
    clk_en = 1'b0;
    cyc(30);
    chk(r, 1'b1);
    clk_en = 1'b1;
    cyc(19);
    chk(r, 1'b1);
    cyc(3);
    chk(r, 1'b0);
  endtask

  initial begin
    t_start;
    t_glitch;
    t_manual;
    t_supply;
    t_freeze;
    conclude;
  end

  initial begin
    #20000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
